// ---- design/ppr_pkg.sv ----
// Purpose: shared constants and carrier types for the port receive block
// Assumes: 8-bit register addresses, 32-bit register data
// Notes: offsets are the register addresses on the register port
package ppr_pkg;

  // register addresses
  localparam logic [7:0] ADDR_LS_ERR_CNT = 8'hA6;
  localparam logic [7:0] ADDR_GAP_ERR_CNT = 8'hAE;
  localparam logic [7:0] ADDR_GAP = 8'hB5;
  localparam logic [7:0] ADDR_UPPER = 8'hB6;
  localparam logic [7:0] ADDR_LOWER = 8'hB7;
  localparam logic [7:0] ADDR_LO_FRAMES = 8'hB8;
  localparam logic [7:0] ADDR_HI_FRAMES = 8'hB9;
  localparam logic [7:0] ADDR_LO_HW = 8'hBA;
  localparam logic [7:0] ADDR_HI_HW = 8'hBB;
  localparam logic [7:0] ADDR_FWD_HW = 8'hBC;
  localparam logic [7:0] ADDR_HEAD_SIZE = 8'hC0;
  localparam logic [7:0] ADDR_RX_DATA = 8'hC1;

  // field top bits
  localparam int GAP_MSB = 5;
  localparam int LEN_MSB = 15;
  localparam int FRM_MSB = 8;
  localparam int HW_MSB = 13;
  localparam int SIZE_MSB = 10;

  // reset values
  localparam logic [5:0] GAP_RST = 6'h0A;
  localparam logic [15:0] UPPER_RST = 16'h0618;
  localparam logic [15:0] LOWER_RST = 16'h0040;

  // gap unit in bit times, one link cycle carries one byte
  localparam logic [9:0] GAP_UNIT_BITS = 10'h008;
  localparam logic [6:0] IDLE_MAX = 7'h7F;
  localparam logic [15:0] LEN_MAX = 16'hFFFF;
  localparam logic [10:0] WORD_BYTES = 11'h004;

  // head frame memory
  localparam int MEM_AW = 9;
  localparam logic [9:0] MEM_DEPTH = 10'h200;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ppr_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } ppr_reg_ans_t;

  typedef struct packed {
    logic dv;
    logic hiPri;
  } ppr_phy_rx_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } ppr_wr_t;

  typedef struct packed {
    logic loPop;
    logic hiPop;
    logic [13:0] loPopHw;
    logic [13:0] hiPopHw;
    logic [13:0] fwdPushHw;
    logic [13:0] fwdPopHw;
  } ppr_q_evt_t;

  typedef struct packed {
    logic hiPri;
    logic [6:0] gap;
    logic [15:0] len;
  } ppr_frame_t;

  typedef enum logic {HEAD_WAIT, HEAD_ARMED} ppr_head_t;

endpackage

// ---- design/ppr_mem.sv ----
// Purpose: word memory for the head frame queue
// Assumes: one write and one read port on the same clock
// Notes: read data is registered, old data on a same-address collision
`timescale 1ns/100ps
module ppr_mem (
  input wire logic clk, // system clock
  input wire logic wrEn, // write strobe
  input wire logic [ppr_pkg::MEM_AW-1:0] wrAddr, // write address
  input wire logic [31:0] wrData, // write word
  input wire logic [ppr_pkg::MEM_AW-1:0] rdAddr, // read address
  output logic [31:0] rdData // registered read word
);

  logic [31:0] store [0:(1 << ppr_pkg::MEM_AW)-1];

  // storage has no reset, pointers outside guard validity
  always_ff @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // registered read
  always_ff @(posedge clk) begin
    rdData <= store[rdAddr];
  end

endmodule // ppr_mem

// ---- design/ppr_port_rx.sv ----
// Purpose: port receive limits, gap check and queue status registers
// Assumes: phy byte per link clock, link clock runs during idle
// Notes: reads answer two cycles after the request, one read in flight
`timescale 1ns/100ps
module ppr_port_rx (
  input wire logic clk, // system clock, 40 MHz
  input wire logic rst_b, // async reset, active low
  input wire ppr_pkg::ppr_reg_req_t regReq, // register request
  output ppr_pkg::ppr_reg_ans_t regAns, // register read answer
  input wire logic linkClk, // phy receive clock
  input wire ppr_pkg::ppr_phy_rx_t phyRx, // phy receive, on linkClk
  input wire ppr_pkg::ppr_wr_t headWr, // head queue word write
  output logic headWrReady, // head queue has room
  input wire ppr_pkg::ppr_q_evt_t qEvt, // queue pop and push events
  input wire logic spiGenericPin, // generic spi mode strap pin
  output logic receiveFrameReady, // a frame waits in a queue
  output logic rxGapErrorFlag // one-cycle pulse per gap error
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // gap in bit times from a byte count
  function automatic logic [9:0] gap_bits(input logic [6:0] bytes);
    gap_bits = 10'(10'(bytes) * ppr_pkg::GAP_UNIT_BITS);
  endfunction

  // half words needed for a frame of len bytes, rounded up
  function automatic logic [13:0] halfwords(input logic [15:0] len);
    logic [16:0] sum;
    sum = 17'(len) + 17'h0_0001;
    halfwords = 14'(sum >> 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link domain

  logic [1:0] linkRstSync;
  logic linkRst_b;
  logic dvQ;
  logic hiQ;
  logic dvPrev;
  logic [6:0] idleCnt;
  logic [15:0] lenCnt;
  logic [6:0] frGap;
  logic frHi;
  ppr_pkg::ppr_frame_t linkRes;
  logic linkTgl;

  // reset asserts at once, releases on the link clock
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      linkRstSync <= 2'b00;
    end else begin
      linkRstSync <= {linkRstSync[0], 1'b1};
    end
  end
  assign linkRst_b = linkRstSync[1];

  // input register on the phy pins
  always_ff @(posedge linkClk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      dvQ <= 1'b0;
      hiQ <= 1'b0;
      dvPrev <= 1'b0;
    end else begin
      dvQ <= phyRx.dv;
      hiQ <= phyRx.hiPri;
      dvPrev <= dvQ;
    end
  end

  // idle bytes, saturating; starts full so the first frame passes
  always_ff @(posedge linkClk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      idleCnt <= ppr_pkg::IDLE_MAX;
    end else if (dvQ) begin
      idleCnt <= 7'h00;
    end else if (idleCnt != ppr_pkg::IDLE_MAX) begin
      idleCnt <= idleCnt + 7'h01;
    end
  end

  // frame length and the gap that preceded it
  always_ff @(posedge linkClk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      lenCnt <= 16'h0000;
      frGap <= 7'h00;
      frHi <= 1'b0;
    end else if (dvQ && !dvPrev) begin
      lenCnt <= 16'h0001;
      frGap <= idleCnt;
      frHi <= hiQ;
    end else if (dvQ && lenCnt != ppr_pkg::LEN_MAX) begin
      lenCnt <= lenCnt + 16'h0001;
    end
  end

  // frame result held stable while its toggle crosses
  always_ff @(posedge linkClk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      linkRes <= '0;
      linkTgl <= 1'b0;
    end else if (!dvQ && dvPrev) begin
      linkRes <= '{hiPri: frHi, gap: frGap, len: lenCnt};
      linkTgl <= ~linkTgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossings into the system domain

  logic [2:0] tglSync;
  logic [1:0] genSync;
  logic spiGeneric;
  logic evt;
  logic evtD;
  ppr_pkg::ppr_frame_t rxFrame;

  // toggle synchroniser; bit 0 is read only by bit 1
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tglSync <= 3'b000;
      genSync <= 2'b00;
    end else begin
      tglSync <= {tglSync[1:0], linkTgl};
      genSync <= {genSync[0], spiGenericPin};
    end
  end
  assign evt = tglSync[2] ^ tglSync[1];
  assign spiGeneric = genSync[1];

  // result word is quiet by the time the toggle arrives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxFrame <= '0;
      evtD <= 1'b0;
    end else begin
      evtD <= evt;
      if (evt) begin
        rxFrame <= linkRes;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [5:0] gapSetting;
  logic [15:0] upperLimit;
  logic [15:0] lowerLimit;

  // software writes, taken on the request edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gapSetting <= ppr_pkg::GAP_RST;
      upperLimit <= ppr_pkg::UPPER_RST;
      lowerLimit <= ppr_pkg::LOWER_RST;
    end else if (regReq.wr) begin
      case (regReq.addr)
        ppr_pkg::ADDR_GAP: gapSetting <= regReq.wdata[ppr_pkg::GAP_MSB:0];
        ppr_pkg::ADDR_UPPER: upperLimit <= regReq.wdata[ppr_pkg::LEN_MSB:0];
        ppr_pkg::ADDR_LOWER: lowerLimit <= regReq.wdata[ppr_pkg::LEN_MSB:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame checks and counters

  logic gapErr;
  logic lenErr;
  logic accept;
  logic accLo;
  logic accHi;
  logic [13:0] hw;
  logic [31:0] gapErrCnt;
  logic [31:0] lsErrCnt;
  logic [8:0] loFrames;
  logic [8:0] hiFrames;
  logic [13:0] loHw;
  logic [13:0] hiHw;
  logic [13:0] fwdHw;

  // gap must strictly exceed the setting, equal counts fail
  assign gapErr = gap_bits(rxFrame.gap)
                  <= gap_bits({1'b0, gapSetting});
  assign lenErr = (rxFrame.len < lowerLimit) || (rxFrame.len > upperLimit);
  assign accept = evtD && !gapErr && !lenErr;
  assign accLo = accept && !rxFrame.hiPri;
  assign accHi = accept && rxFrame.hiPri;
  assign hw = halfwords(rxFrame.len);

  // error counters and the gap error pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gapErrCnt <= 32'h0000_0000;
      lsErrCnt <= 32'h0000_0000;
      rxGapErrorFlag <= 1'b0;
    end else begin
      rxGapErrorFlag <= evtD && gapErr;
      if (evtD && gapErr) begin
        gapErrCnt <= gapErrCnt + 32'h0000_0001;
      end
      if (evtD && lenErr) begin
        lsErrCnt <= lsErrCnt + 32'h0000_0001;
      end
    end
  end

  // occupancy; a push and a pop in one cycle both count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loFrames <= 9'h000;
      hiFrames <= 9'h000;
      loHw <= 14'h0000;
      hiHw <= 14'h0000;
      fwdHw <= 14'h0000;
    end else begin
      loFrames <= loFrames + 9'(accLo) - 9'(qEvt.loPop);
      hiFrames <= hiFrames + 9'(accHi) - 9'(qEvt.hiPop);
      loHw <= loHw + (accLo ? hw : 14'h0000) - qEvt.loPopHw;
      hiHw <= hiHw + (accHi ? hw : 14'h0000) - qEvt.hiPopHw;
      fwdHw <= fwdHw + qEvt.fwdPushHw - qEvt.fwdPopHw;
    end
  end

  // host polls this rather than the debug counts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      receiveFrameReady <= 1'b0;
    end else begin
      receiveFrameReady <= (loFrames != 9'h000)
                           || (hiFrames != 9'h000);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // head frame queue

  logic [ppr_pkg::MEM_AW-1:0] wrPtr;
  logic [ppr_pkg::MEM_AW-1:0] rdPtr;
  logic [9:0] memCount;
  logic [9:0] next_memCount;
  logic memAvail;
  logic [31:0] memQ;
  logic wrTake;
  logic memPop;

  assign wrTake = headWr.valid && headWrReady;
  assign next_memCount = memCount + 10'(wrTake) - 10'(memPop);

  ppr_mem u_mem (
    .clk(clk),
    .wrEn(wrTake),
    .wrAddr(wrPtr),
    .wrData(headWr.data),
    .rdAddr(rdPtr),
    .rdData(memQ)
  );

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      memCount <= 10'h000;
      headWrReady <= 1'b1;
    end else begin
      wrPtr <= wrPtr + ppr_pkg::MEM_AW'(wrTake);
      rdPtr <= rdPtr + ppr_pkg::MEM_AW'(memPop);
      memCount <= next_memCount;
      headWrReady <= next_memCount < ppr_pkg::MEM_DEPTH;
    end
  end

  // lags the count a cycle so memQ is settled when it says so
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      memAvail <= 1'b0;
    end else begin
      memAvail <= memCount != 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path and frame drain

  logic rdTake;
  logic rdPend;
  logic [7:0] rdAddr;
  logic headRead;
  logic headPop;
  logic dataRead;
  logic [10:0] headSize;
  logic [10:0] remain;
  logic [10:0] headValue;
  logic [31:0] dataValue;
  logic [31:0] rdValue;
  ppr_pkg::ppr_head_t headState;

  // a read during the pending cycle is ignored
  assign rdTake = regReq.rd && !regReq.wr && !rdPend;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPend <= 1'b0;
      rdAddr <= 8'h00;
    end else begin
      rdPend <= rdTake;
      if (rdTake) begin
        rdAddr <= regReq.addr;
      end
    end
  end

  // the first size word of a frame is consumed by the size read
  assign headRead = rdPend && (rdAddr == ppr_pkg::ADDR_HEAD_SIZE)
                    && spiGeneric;
  assign headPop = headRead && (headState == ppr_pkg::HEAD_WAIT)
                   && memAvail;
  assign dataRead = rdPend && (rdAddr == ppr_pkg::ADDR_RX_DATA)
                    && spiGeneric && (headState == ppr_pkg::HEAD_ARMED)
                    && memAvail;
  assign memPop = headPop || dataRead;

  // size shown to the host
  always_comb begin
    headValue = 11'h000;
    if (!spiGeneric) begin
      headValue = 11'h000;
    end else if (headState == ppr_pkg::HEAD_ARMED) begin
      headValue = headSize;
    end else if (memAvail) begin
      headValue = memQ[ppr_pkg::SIZE_MSB:0];
    end
  end

  // first byte of the word sits in the top lane of memQ
  assign dataValue = dataRead ? memQ : 32'h0000_0000;

  // drain state; a zero size never arms
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      headState <= ppr_pkg::HEAD_WAIT;
    end else begin
      unique case (headState)
        ppr_pkg::HEAD_WAIT:
          if (headPop && memQ[ppr_pkg::SIZE_MSB:0] != 11'h000) begin
            headState <= ppr_pkg::HEAD_ARMED;
          end
        ppr_pkg::HEAD_ARMED:
          if (dataRead && remain <= ppr_pkg::WORD_BYTES) begin
            headState <= ppr_pkg::HEAD_WAIT;
          end
      endcase
    end
  end

  // bytes of the armed frame still to be read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      headSize <= 11'h000;
      remain <= 11'h000;
    end else if (headPop) begin
      headSize <= memQ[ppr_pkg::SIZE_MSB:0];
      remain <= memQ[ppr_pkg::SIZE_MSB:0];
    end else if (dataRead) begin
      remain <= (remain <= ppr_pkg::WORD_BYTES) ? 11'h000
                : remain - ppr_pkg::WORD_BYTES;
    end
  end

  // register read mux, reserved bits zero, unmapped reads zero
  always_comb begin
    rdValue = 32'h0000_0000;
    case (rdAddr)
      ppr_pkg::ADDR_GAP: rdValue = 32'(gapSetting);
      ppr_pkg::ADDR_UPPER: rdValue = 32'(upperLimit);
      ppr_pkg::ADDR_LOWER: rdValue = 32'(lowerLimit);
      ppr_pkg::ADDR_LO_FRAMES: rdValue = 32'(loFrames);
      ppr_pkg::ADDR_HI_FRAMES: rdValue = 32'(hiFrames);
      ppr_pkg::ADDR_LO_HW: rdValue = 32'(loHw);
      ppr_pkg::ADDR_HI_HW: rdValue = 32'(hiHw);
      ppr_pkg::ADDR_FWD_HW: rdValue = 32'(fwdHw);
      ppr_pkg::ADDR_LS_ERR_CNT: rdValue = lsErrCnt;
      ppr_pkg::ADDR_GAP_ERR_CNT: rdValue = gapErrCnt;
      ppr_pkg::ADDR_HEAD_SIZE: rdValue = 32'(headValue);
      ppr_pkg::ADDR_RX_DATA: rdValue = dataValue;
      default: rdValue = 32'h0000_0000;
    endcase
  end

  // answer register, valid for one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regAns <= '0;
    end else begin
      regAns.valid <= rdPend;
      if (rdPend) begin
        regAns.rdata <= rdValue;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_gap_pass;
    @(posedge clk) disable iff (!rst_b)
    (evtD && !lenErr && !rxFrame.hiPri && !qEvt.loPop
     && gap_bits(rxFrame.gap) > gap_bits({1'b0, gapSetting}))
    |=> loFrames == $past(loFrames) + 9'h001;
  endproperty
  a_gap_pass: assert property (p_gap_pass)
    else $error("frame with enough gap not queued");

  property p_gap_error;
    @(posedge clk) disable iff (!rst_b)
    (evtD && gapErr) |=> rxGapErrorFlag
    && gapErrCnt == $past(gapErrCnt) + 32'h0000_0001
    && loFrames == $past(loFrames) - 9'($past(qEvt.loPop));
  endproperty
  a_gap_error: assert property (p_gap_error)
    else $error("gap error not flagged or counted");

  property p_gap_write;
    @(posedge clk) disable iff (!rst_b)
    (regReq.wr && regReq.addr == ppr_pkg::ADDR_GAP)
    |=> gapSetting == 6'($past(regReq.wdata));
  endproperty
  a_gap_write: assert property (p_gap_write)
    else $error("gap setting write lost");

  property p_upper_write;
    @(posedge clk) disable iff (!rst_b)
    (regReq.wr && regReq.addr == ppr_pkg::ADDR_UPPER)
    |=> upperLimit == 16'($past(regReq.wdata));
  endproperty
  a_upper_write: assert property (p_upper_write)
    else $error("upper limit write lost");

  property p_lower_write;
    @(posedge clk) disable iff (!rst_b)
    (regReq.wr && regReq.addr == ppr_pkg::ADDR_LOWER)
    |=> lowerLimit == 16'($past(regReq.wdata));
  endproperty
  a_lower_write: assert property (p_lower_write)
    else $error("lower limit write lost");

  property p_ready;
    @(posedge clk) disable iff (!rst_b)
    (hiFrames != 9'h000) |=> receiveFrameReady;
  endproperty
  a_ready: assert property (p_ready)
    else $error("receive ready low with frames queued");

  property p_lo_hw;
    @(posedge clk) disable iff (!rst_b)
    (accLo && qEvt.loPopHw == 14'h0000) |=> loHw == $past(loHw) + $past(hw);
  endproperty
  a_lo_hw: assert property (p_lo_hw)
    else $error("low queue half words not updated");

  property p_fwd_hw;
    @(posedge clk) disable iff (!rst_b)
    (qEvt.fwdPopHw == 14'h0000)
    |=> fwdHw == $past(fwdHw) + $past(qEvt.fwdPushHw);
  endproperty
  a_fwd_hw: assert property (p_fwd_hw)
    else $error("forward queue half words not updated");

  property p_head;
    @(posedge clk) disable iff (!rst_b)
    headPop |=> regAns.valid && regAns.rdata == 32'(headSize);
  endproperty
  a_head: assert property (p_head)
    else $error("head size answer wrong");

  property p_pop;
    @(posedge clk) disable iff (!rst_b)
    dataRead |=> rdPtr == $past(rdPtr) + 9'h001
    && regAns.rdata == $past(memQ);
  endproperty
  a_pop: assert property (p_pop)
    else $error("data read did not return and pop a word");

  property p_frame_end;
    @(posedge clk) disable iff (!rst_b)
    (rdPend && rdAddr == ppr_pkg::ADDR_RX_DATA
     && headState == ppr_pkg::HEAD_WAIT)
    |=> regAns.rdata == 32'h0000_0000 && rdPtr == $past(rdPtr);
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("data returned without a size read");

  property p_mode;
    @(posedge clk) disable iff (!rst_b)
    (rdPend && rdAddr == ppr_pkg::ADDR_HEAD_SIZE && !spiGeneric)
    |=> regAns.rdata == 32'h0000_0000 && rdPtr == $past(rdPtr);
  endproperty
  a_mode: assert property (p_mode)
    else $error("head size served outside generic mode");

  c_accept: cover property (@(posedge clk) disable iff (!rst_b) accept);
  c_gap_err: cover property (@(posedge clk) disable iff (!rst_b)
    evtD && gapErr);
  c_head_pop: cover property (@(posedge clk) disable iff (!rst_b) headPop);
  c_drained: cover property (@(posedge clk) disable iff (!rst_b)
    dataRead && remain <= ppr_pkg::WORD_BYTES);

endmodule // ppr_port_rx

// ---- sim/ppr_host_model.sv ----
// Purpose: host side register master for the port receive block
// Assumes: register port takes a request at a clk edge
// Notes: one read in flight, request held for one cycle only
`timescale 1ns/100ps
module ppr_host_model (
  input wire logic clk, // system clock
  output ppr_pkg::ppr_reg_req_t req, // register request
  input wire ppr_pkg::ppr_reg_ans_t ans // register answer
);
////////////////////////////////////////////////////////////////////////
  // idle request from time zero
  initial begin
    req = '0;
  end

  // write, applied at the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) req <= '{rd:1'b0, wr:1'b1, addr:a, wdata:d};
    @(posedge clk) req <= '0;
  endtask

  // read; bounded wait so a lost answer cannot hang the host
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk) req <= '{rd:1'b1, wr:1'b0, addr:a, wdata:'0};
    @(posedge clk) req <= '0;
    n = 0;
    while (ans.valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    d = (n < 8) ? ans.rdata : 32'hFFFF_FFFF;
  endtask
endmodule // ppr_host_model

// ---- sim/ppr_port_rx_test.sv ----
// Purpose: self-checking bench for the port receive block
// Assumes: host model drives the register port
// Notes: link clock runs free, one frame byte per link edge
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  numErrors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ppr_port_rx_test;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic clk, linkClk, rst_b, spiGenericPin;
  logic headWrReady, receiveFrameReady, rxGapErrorFlag;
  ppr_pkg::ppr_phy_rx_t phyRx;
  ppr_pkg::ppr_wr_t headWr;
  ppr_pkg::ppr_q_evt_t qEvt;
  ppr_pkg::ppr_reg_req_t regReq;
  ppr_pkg::ppr_reg_ans_t regAns;
  int numErrors, compares, gapPulses;
////////////////////////////////////////////////////////////////////////
  // clocks, link phase offset on purpose
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #62.5 linkClk = ~linkClk;
  end

  ppr_port_rx u_ppr_port_rx (.clk(clk), .rst_b(rst_b), .regReq(regReq),
    .regAns(regAns), .linkClk(linkClk), .phyRx(phyRx), .headWr(headWr),
    .headWrReady(headWrReady), .qEvt(qEvt), .spiGenericPin(spiGenericPin),
    .receiveFrameReady(receiveFrameReady), .rxGapErrorFlag(rxGapErrorFlag));
  ppr_host_model u_ppr_host_model (.clk(clk), .req(regReq), .ans(regAns));

  // gap error pulses, one per frame dropped for its gap; length drops give none
  always @(posedge clk) if (rxGapErrorFlag === 1'b1) gapPulses++;
////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ppr_host_model.wr(a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    logic [31:0] d;
    u_ppr_host_model.rd(a, d);
    `CHK(nm, e, d)
  endtask
  // word into head queue; drop valid at the accepting edge
  task automatic wrHead(input logic [31:0] d);
    @(posedge clk) headWr <= '{valid:1'b1, data:d};
    @(posedge clk);
    while (headWrReady !== 1'b1) @(posedge clk);
    headWr <= '0;
  endtask
  // g+1 idle link cycles, then len bytes
  task automatic frame(input int g, input int len, input logic hi);
    repeat (g) @(posedge linkClk);
    @(posedge linkClk) phyRx <= '{dv:1'b1, hiPri:hi};
    repeat (len - 1) @(posedge linkClk);
    @(posedge linkClk) phyRx <= '0;
  endtask
  task automatic settle;
    repeat (16) @(posedge linkClk);
  endtask
////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(ppr_pkg::ADDR_GAP, 32'h0000_000A, "gap");
    chk(ppr_pkg::ADDR_UPPER, 32'h0000_0618, "upper");
    chk(ppr_pkg::ADDR_LOWER, 32'h0000_0040, "lower");
    chk(ppr_pkg::ADDR_LO_FRAMES, ZERO, "loFrm");
    chk(ppr_pkg::ADDR_HI_FRAMES, ZERO, "hiFrm");
    chk(ppr_pkg::ADDR_LO_HW, ZERO, "loHw");
    chk(ppr_pkg::ADDR_HI_HW, ZERO, "hiHw");
    chk(ppr_pkg::ADDR_FWD_HW, ZERO, "fwdHw");
    chk(ppr_pkg::ADDR_HEAD_SIZE, ZERO, "size");
    chk(8'hFF, ZERO, "unmapped");
    `CHK("ready", 1'b0, receiveFrameReady)
    `CHK("wrReady", 1'b1, headWrReady)
    $display("t_reset done");
  endtask
  // reserved bits read zero, read-only ignores writes
  task automatic t_regs;
    wr(ppr_pkg::ADDR_GAP, 32'hFFFF_FFFF);
    chk(ppr_pkg::ADDR_GAP, 32'h0000_003F, "gapMax");
    wr(ppr_pkg::ADDR_LO_FRAMES, 32'h0000_0055);
    chk(ppr_pkg::ADDR_LO_FRAMES, ZERO, "roFrm");
    wr(ppr_pkg::ADDR_UPPER, 32'hABCD_0008);
    chk(ppr_pkg::ADDR_UPPER, 32'h0000_0008, "upperW");
    wr(ppr_pkg::ADDR_LOWER, 32'h0000_0004);
    chk(ppr_pkg::ADDR_LOWER, 32'h0000_0004, "lowerW");
    wr(ppr_pkg::ADDR_GAP, 32'h0000_0003);
    $display("t_regs done");
  endtask
  // gap equal to setting fails, a gap of 20 passes; upper limit inclusive
  task automatic t_frames;
    frame(19, 5, 1'b1);
    frame(2, 8, 1'b0);
    settle;
    `CHK("gapPulse", 1, gapPulses)
    frame(3, 8, 1'b0);
    settle;
    frame(19, 3, 1'b0);
    settle;
    frame(19, 9, 1'b0);
    settle;
    chk(ppr_pkg::ADDR_GAP_ERR_CNT, 32'h0000_0001, "gapCnt");
    chk(ppr_pkg::ADDR_LS_ERR_CNT, 32'h0000_0002, "lenCnt");
    chk(ppr_pkg::ADDR_HI_FRAMES, 32'h0000_0001, "hiFrm");
    chk(ppr_pkg::ADDR_HI_HW, 32'h0000_0003, "hiHw");
    chk(ppr_pkg::ADDR_LO_FRAMES, 32'h0000_0001, "loFrm");
    chk(ppr_pkg::ADDR_LO_HW, 32'h0000_0004, "loHw");
    `CHK("ready", 1'b1, receiveFrameReady)
    $display("t_frames done");
  endtask
  // pops drain, push and pop in one cycle both count
  task automatic t_queue;
    @(posedge clk) qEvt <= '{hiPop:1'b1, hiPopHw:14'h0003,
                            fwdPushHw:14'h0005, default:'0};
    @(posedge clk) qEvt <= '{loPop:1'b1, loPopHw:14'h0004,
                            fwdPushHw:14'h0001, fwdPopHw:14'h0002,
                            default:'0};
    @(posedge clk) qEvt <= '0;
    chk(ppr_pkg::ADDR_HI_FRAMES, ZERO, "hiPop");
    chk(ppr_pkg::ADDR_HI_HW, ZERO, "hiHwPop");
    chk(ppr_pkg::ADDR_LO_FRAMES, ZERO, "loPop");
    chk(ppr_pkg::ADDR_LO_HW, ZERO, "loHwPop");
    chk(ppr_pkg::ADDR_FWD_HW, 32'h0000_0004, "fwdHw");
    `CHK("readyOff", 1'b0, receiveFrameReady)
    $display("t_queue done");
  endtask
  // size first, then words; size reads zero outside generic mode
  task automatic t_head;
    wrHead(32'h0000_0006);
    wrHead(32'h1122_3344);
    wrHead(32'h5566_0000);
    repeat (3) @(posedge clk);
    chk(ppr_pkg::ADDR_RX_DATA, ZERO, "early");
    chk(ppr_pkg::ADDR_HEAD_SIZE, 32'h0000_0006, "size");
    chk(ppr_pkg::ADDR_HEAD_SIZE, 32'h0000_0006, "size2");
    chk(ppr_pkg::ADDR_RX_DATA, 32'h1122_3344, "w0");
    chk(ppr_pkg::ADDR_RX_DATA, 32'h5566_0000, "w1");
    chk(ppr_pkg::ADDR_RX_DATA, ZERO, "after");
    wrHead(32'h0000_0004);
    wrHead(32'hA1B2_C3D4);
    @(posedge clk) spiGenericPin <= 1'b0;
    repeat (4) @(posedge clk);
    chk(ppr_pkg::ADDR_HEAD_SIZE, ZERO, "mode");
    @(posedge clk) spiGenericPin <= 1'b1;
    repeat (4) @(posedge clk);
    chk(ppr_pkg::ADDR_HEAD_SIZE, 32'h0000_0004, "size3");
    chk(ppr_pkg::ADDR_RX_DATA, 32'hA1B2_C3D4, "w2");
    $display("t_head done");
  endtask
////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    spiGenericPin = 1'b1;
    phyRx = '0;
    headWr = '0;
    qEvt = '0;
    numErrors = 0;
    compares = 0;
    gapPulses = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_regs;
    t_frames;
    t_queue;
    t_head;
    complete_run;
  end

  // watchdog, far beyond the expected run of about 25 us
  initial begin
    #200000;
    numErrors++;
    complete_run;
  end
endmodule // ppr_port_rx_test
